// File: verilog/pcr_pkg.sv
package pcr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int          PCR_NREGS     = 8;
   localparam logic [15:0] PCR_ADDR_RMIX = 16'h4021;
   localparam logic [15:0] PCR_ADDR_MONO = 16'h4022;
   localparam logic [15:0] PCR_ADDR_LHP  = 16'h4023;
   localparam logic [15:0] PCR_ADDR_RHP  = 16'h4024;
   localparam logic [15:0] PCR_ADDR_LLO  = 16'h4025;
   localparam logic [15:0] PCR_ADDR_RLO  = 16'h4026;
   localparam logic [15:0] PCR_ADDR_MOUT = 16'h4027;
   localparam logic [15:0] PCR_ADDR_POP  = 16'h4028;
   localparam logic [15:0] PCR_ADDR_BASE = PCR_ADDR_RMIX;

   localparam logic [2:0] PCR_IDX_RMIX = 3'h0;
   localparam logic [2:0] PCR_IDX_MONO = 3'h1;
   localparam logic [2:0] PCR_IDX_LHP  = 3'h2;
   localparam logic [2:0] PCR_IDX_RHP  = 3'h3;
   localparam logic [2:0] PCR_IDX_LLO  = 3'h4;
   localparam logic [2:0] PCR_IDX_RLO  = 3'h5;
   localparam logic [2:0] PCR_IDX_MOUT = 3'h6;
   localparam logic [2:0] PCR_IDX_POP  = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   localparam int PCR_BOOST_R_LSB = 3;
   localparam int PCR_BOOST_L_LSB = 1;
   localparam int PCR_MODE2_LSB   = 1;
   localparam int PCR_EN_BIT      = 0;
   localparam int PCR_VOL_LSB     = 2;
   localparam int PCR_UNMUTE_BIT  = 1;
   localparam int PCR_MODE_BIT    = 0;
   localparam int PCR_POP_PWR_BIT = 4;
   localparam int PCR_POP_DIS_BIT = 3;
   localparam int PCR_SLEW_LSB    = 1;

   // Reset values, index 7 first
   localparam logic [7:0] PCR_RST_RMIX = 8'h00;
   localparam logic [7:0] PCR_RST_MONO = 8'h00;
   localparam logic [7:0] PCR_RST_VOL  = 8'h02;
   localparam logic [7:0] PCR_RST_POP  = 8'h00;
   localparam logic [PCR_NREGS-1:0][7:0] PCR_RST_TABLE =
      {PCR_RST_POP, PCR_RST_VOL, PCR_RST_VOL, PCR_RST_VOL,
       PCR_RST_VOL, PCR_RST_VOL, PCR_RST_MONO, PCR_RST_RMIX};

   // Implemented bits; reserved ones store nothing and read zero
   localparam logic [7:0] PCR_MASK_RMIX = 8'h1F;
   localparam logic [7:0] PCR_MASK_MONO = 8'h07;
   localparam logic [7:0] PCR_MASK_VOL  = 8'hFF;
   localparam logic [7:0] PCR_MASK_POP  = 8'h1E;
   localparam logic [PCR_NREGS-1:0][7:0] PCR_MASK_TABLE =
      {PCR_MASK_POP, PCR_MASK_VOL, PCR_MASK_VOL, PCR_MASK_VOL,
       PCR_MASK_VOL, PCR_MASK_VOL, PCR_MASK_MONO, PCR_MASK_RMIX};

   // Volume code 0 is -57 dB, two's complement in 7 bits
   localparam logic [6:0] PCR_VOL_MIN_DB   = 7'h47;
   localparam logic [5:0] PCR_VOL_0DB_CODE = 6'h39;
   localparam logic [5:0] PCR_VOL_MAX_CODE = 6'h3F;

   ////////////////////////////////////////////////////////////////////////////
   localparam int PCR_CLK_MHZ        = 100;
   localparam int PCR_SLEW_SHORT_US  = 21250;
   localparam int PCR_SLEW_MID_US    = 42500;
   localparam int PCR_SLEW_LONG_US   = 85000;
   localparam int PCR_SLEW_SHORT_CYC = PCR_SLEW_SHORT_US * PCR_CLK_MHZ;
   localparam int PCR_SLEW_MID_CYC   = PCR_SLEW_MID_US * PCR_CLK_MHZ;
   localparam int PCR_SLEW_LONG_CYC  = PCR_SLEW_LONG_US * PCR_CLK_MHZ;
   localparam int PCR_SLEW_CW        = 24;

   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      PCR_BOOST_MUTE = 2'h0,
      PCR_BOOST_0DB  = 2'h1,
      PCR_BOOST_6DB  = 2'h2,
      PCR_BOOST_RSVD = 2'h3
   } pcr_boost_t;

   typedef enum logic [1:0] {
      PCR_MONO_CM   = 2'h0,
      PCR_MONO_0DB  = 2'h1,
      PCR_MONO_6DB  = 2'h2,
      PCR_MONO_RSVD = 2'h3
   } pcr_mono_mode_t;

   typedef enum logic [1:0] {
      PCR_SLEW_SHORT = 2'h0,
      PCR_SLEW_MID   = 2'h1,
      PCR_SLEW_LONG  = 2'h2,
      PCR_SLEW_OFF   = 2'h3
   } pcr_slew_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } pcr_ctl_req_t;

   typedef struct packed {
      pcr_boost_t     rmix_from_right_boost;
      pcr_boost_t     rmix_from_left_boost;
      logic           right_out_mixer_enable;
      pcr_mono_mode_t mono_mixer_mode;
      logic           mono_mixer_enable;
      logic [5:0]     left_phones_volume;
      logic           left_phones_unmute;
      logic           phones_volume_enable;
      logic [5:0]     right_phones_volume;
      logic           right_phones_unmute;
      logic           phones_output_mode;
      logic [5:0]     left_line_volume;
      logic           left_line_unmute;
      logic           left_line_mode;
      logic [5:0]     right_line_volume;
      logic           right_line_unmute;
      logic           right_line_mode;
      logic [5:0]     mono_volume;
      logic           mono_unmute;
      logic           mono_output_mode;
      logic           pop_suppress_power_sel;
      logic           pop_suppress_disable;
      pcr_slew_t      volume_slew_sel;
   } pcr_cfg_t;

   typedef struct packed {
      logic phones_enable;
      logic mono_volume_active;
      logic volume_slewing;
   } pcr_stat_t;

endpackage

// File: verilog/pcr_reg8.sv
`timescale 1ns/10ps
`default_nettype none

module pcr_reg8
#(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] BIT_MASK    = 8'hFF
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Write side
   input  wire logic       we,
   input  wire logic [7:0] wdata,
   // Stored value
   output logic      [7:0] q
);

   // Reserved bits never hold a one, so readback needs no extra masking
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         q <= RESET_VALUE & BIT_MASK;
      end
      else if (we)
      begin
         q <= wdata & BIT_MASK;
      end
   end

endmodule

`default_nettype wire

// File: verilog/pcr_playback_output_control_regs.sv
`timescale 1ns/10ps
`default_nettype none

module pcr_playback_output_control_regs
   import pcr_pkg::*;
#(
   parameter int SLEW_SHORT_CYCLES = PCR_SLEW_SHORT_CYC,
   parameter int SLEW_MID_CYCLES   = PCR_SLEW_MID_CYC,
   parameter int SLEW_LONG_CYCLES  = PCR_SLEW_LONG_CYC
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Control port
   input  wire pcr_ctl_req_t ctl_req,
   output logic [7:0]        ctl_rdata,
   output logic              ctl_rvalid,
   // Settings for the analog output stage
   output pcr_cfg_t          cfg,
   output pcr_stat_t         stat,
   // Gain in dB per volume register, index 0 is left phones
   output logic [4:0][6:0]   out_gain_db
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic [15:0] addr_off;
   logic        addr_hit;
   logic [2:0]  addr_idx;
   logic        vol_write;

   assign addr_off = ctl_req.addr - PCR_ADDR_BASE;
   assign addr_hit = (addr_off < 16'(PCR_NREGS));
   assign addr_idx = addr_off[2:0];
   assign vol_write = ctl_req.wr && addr_hit &&
                      (addr_idx >= PCR_IDX_LHP) && (addr_idx <= PCR_IDX_MOUT);

   ////////////////////////////////////////////////////////////////////////////
   // Register cells

   logic [7:0] reg_q [PCR_NREGS];

   genvar gi;
   generate
      for (gi = 0; gi < PCR_NREGS; gi++)
      begin : g_reg
         logic cell_we;
         assign cell_we = ctl_req.wr && addr_hit && (addr_idx == 3'(gi));
         pcr_reg8
         #(
            .RESET_VALUE (PCR_RST_TABLE[gi]),
            .BIT_MASK    (PCR_MASK_TABLE[gi])
         )
         u_cell
         (
            .clk   (clk),
            .rst   (rst),
            .we    (cell_we),
            .wdata (ctl_req.wdata),
            .q     (reg_q[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read port; a read in the same cycle as a write returns the old value

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctl_rdata <= 8'h00;
      end
      else if (ctl_req.rd)
      begin
         ctl_rdata <= addr_hit ? reg_q[addr_idx] : 8'h00;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctl_rvalid <= 1'b0;
      end
      else
      begin
         ctl_rvalid <= ctl_req.rd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Field view of the cells

   // Reserved codes pass through unchanged; the analog stage owns their effect
   assign cfg.rmix_from_right_boost =
      pcr_boost_t'(reg_q[PCR_IDX_RMIX][PCR_BOOST_R_LSB +: 2]);
   assign cfg.rmix_from_left_boost =
      pcr_boost_t'(reg_q[PCR_IDX_RMIX][PCR_BOOST_L_LSB +: 2]);
   assign cfg.right_out_mixer_enable = reg_q[PCR_IDX_RMIX][PCR_EN_BIT];
   assign cfg.mono_mixer_mode =
      pcr_mono_mode_t'(reg_q[PCR_IDX_MONO][PCR_MODE2_LSB +: 2]);
   assign cfg.mono_mixer_enable = reg_q[PCR_IDX_MONO][PCR_EN_BIT];

   assign cfg.left_phones_volume   = reg_q[PCR_IDX_LHP][PCR_VOL_LSB +: 6];
   assign cfg.left_phones_unmute   = reg_q[PCR_IDX_LHP][PCR_UNMUTE_BIT];
   assign cfg.phones_volume_enable = reg_q[PCR_IDX_LHP][PCR_EN_BIT];

   assign cfg.right_phones_volume = reg_q[PCR_IDX_RHP][PCR_VOL_LSB +: 6];
   assign cfg.right_phones_unmute = reg_q[PCR_IDX_RHP][PCR_UNMUTE_BIT];
   assign cfg.phones_output_mode  = reg_q[PCR_IDX_RHP][PCR_MODE_BIT];

   assign cfg.left_line_volume = reg_q[PCR_IDX_LLO][PCR_VOL_LSB +: 6];
   assign cfg.left_line_unmute = reg_q[PCR_IDX_LLO][PCR_UNMUTE_BIT];
   assign cfg.left_line_mode   = reg_q[PCR_IDX_LLO][PCR_MODE_BIT];

   assign cfg.right_line_volume = reg_q[PCR_IDX_RLO][PCR_VOL_LSB +: 6];
   assign cfg.right_line_unmute = reg_q[PCR_IDX_RLO][PCR_UNMUTE_BIT];
   assign cfg.right_line_mode   = reg_q[PCR_IDX_RLO][PCR_MODE_BIT];

   assign cfg.mono_volume      = reg_q[PCR_IDX_MOUT][PCR_VOL_LSB +: 6];
   assign cfg.mono_unmute      = reg_q[PCR_IDX_MOUT][PCR_UNMUTE_BIT];
   // Not forced by hardware; capless setups rely on software here
   assign cfg.mono_output_mode = reg_q[PCR_IDX_MOUT][PCR_MODE_BIT];

   assign cfg.pop_suppress_power_sel = reg_q[PCR_IDX_POP][PCR_POP_PWR_BIT];
   assign cfg.pop_suppress_disable   = reg_q[PCR_IDX_POP][PCR_POP_DIS_BIT];
   assign cfg.volume_slew_sel =
      pcr_slew_t'(reg_q[PCR_IDX_POP][PCR_SLEW_LSB +: 2]);

   ////////////////////////////////////////////////////////////////////////////
   // Decoded enables

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stat.phones_enable <= 1'b0;
      end
      else
      begin
         stat.phones_enable <= cfg.phones_volume_enable | cfg.phones_output_mode;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stat.mono_volume_active <= 1'b0;
      end
      else
      begin
         stat.mono_volume_active <= (cfg.mono_mixer_mode != PCR_MONO_CM);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Volume slew timer, restarted by each volume write

   logic [PCR_SLEW_CW-1:0] slew_cnt_reg;
   logic [PCR_SLEW_CW-1:0] slew_cnt_next;

   // The slew setting in force before the write decides the length
   always_comb
   begin
      slew_cnt_next = slew_cnt_reg;
      if (vol_write)
      begin
         unique case (cfg.volume_slew_sel)
            PCR_SLEW_SHORT: slew_cnt_next = PCR_SLEW_CW'(SLEW_SHORT_CYCLES);
            PCR_SLEW_MID:   slew_cnt_next = PCR_SLEW_CW'(SLEW_MID_CYCLES);
            PCR_SLEW_LONG:  slew_cnt_next = PCR_SLEW_CW'(SLEW_LONG_CYCLES);
            PCR_SLEW_OFF:   slew_cnt_next = '0;
         endcase
      end
      else if (slew_cnt_reg != '0)
      begin
         slew_cnt_next = slew_cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         slew_cnt_reg <= '0;
      end
      else
      begin
         slew_cnt_reg <= slew_cnt_next;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         stat.volume_slewing <= 1'b0;
      end
      else
      begin
         stat.volume_slewing <= (slew_cnt_next != '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gain in dB, one per volume register

   generate
      for (gi = 0; gi < 5; gi++)
      begin : g_gain
         always_ff @(posedge clk or posedge rst)
         begin
            if (rst)
            begin
               out_gain_db[gi] <= PCR_VOL_MIN_DB;
            end
            else
            begin
               out_gain_db[gi] <= {1'b0, reg_q[gi + 2][PCR_VOL_LSB +: 6]}
                                  + PCR_VOL_MIN_DB;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_phones_enable_mode: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_RHP && ctl_req.wdata[0]) |=> ##1 stat.phones_enable)
      else $error("phones not enabled after mode bit write");

   a_phones_enable_off: assert property (
      (!cfg.phones_volume_enable && !cfg.phones_output_mode && !ctl_req.wr) |=> !stat.phones_enable)
      else $error("phones enabled with both bits clear");

   a_mono_vol_gate: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_MONO && ctl_req.wdata[2:1] == 2'h0)
      |=> ##1 !stat.mono_volume_active)
      else $error("mono volume active in common-mode");

   a_lhp_readback: assert property (
      (ctl_req.wr && !ctl_req.rd && ctl_req.addr == PCR_ADDR_LHP
       ##1 ctl_req.rd && !ctl_req.wr && ctl_req.addr == PCR_ADDR_LHP)
      |=> (ctl_rdata == $past(ctl_req.wdata, 2)) && ctl_rvalid)
      else $error("left phones readback mismatch");

   a_pop_reserved: assert property (
      (ctl_req.wr && !ctl_req.rd && ctl_req.addr == PCR_ADDR_POP
       ##1 ctl_req.rd && !ctl_req.wr && ctl_req.addr == PCR_ADDR_POP)
      |=> ctl_rdata == ($past(ctl_req.wdata, 2) & PCR_MASK_POP))
      else $error("pop register reserved bits not zero");

   a_mono_reserved: assert property (
      (ctl_req.rd && ctl_req.addr == PCR_ADDR_MONO) |=> ctl_rdata[7:3] == 5'h00)
      else $error("mono mixer reserved bits not zero");

   a_unmapped_zero: assert property (
      (ctl_req.rd && (ctl_req.addr == 16'h4020 || ctl_req.addr == 16'h4029))
      |=> ctl_rvalid && ctl_rdata == 8'h00)
      else $error("unmapped read not zero");

   a_boost_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_RMIX)
      |=> cfg.rmix_from_right_boost == pcr_boost_t'($past(ctl_req.wdata[4:3]))
          && cfg.rmix_from_left_boost == pcr_boost_t'($past(ctl_req.wdata[2:1])))
      else $error("boost fields not stored");

   a_slew_start: assert property (
      (vol_write && cfg.volume_slew_sel != PCR_SLEW_OFF) |=> stat.volume_slewing [*4])
      else $error("slew timer did not start");

   a_slew_off: assert property (
      (vol_write && cfg.volume_slew_sel == PCR_SLEW_OFF) |=> !stat.volume_slewing)
      else $error("slewing with slew off");

   a_slew_end: assert property (
      (slew_cnt_reg == 24'h000001 && !vol_write) |=> !stat.volume_slewing)
      else $error("slew timer did not end");

   a_gain_decode: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_LHP && ctl_req.wdata[7:2] == PCR_VOL_0DB_CODE)
      |=> ##1 out_gain_db[0] == 7'h00)
      else $error("0 dB code not decoded");

   a_pop_disable: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_POP)
      |=> cfg.pop_suppress_disable == $past(ctl_req.wdata[3])
          && cfg.pop_suppress_power_sel == $past(ctl_req.wdata[4]))
      else $error("pop control bits not stored");

   a_read_valid: assert property (
      ctl_req.rd |=> ctl_rvalid)
      else $error("read valid missing after read");

   a_mono_vol_on: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_MONO && ctl_req.wdata[2:1] != 2'h0)
      |=> ##1 stat.mono_volume_active)
      else $error("mono volume inactive in mixing mode");

   a_lhp_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_LHP)
      |=> cfg.left_phones_volume == $past(ctl_req.wdata[7:2])
          && cfg.left_phones_unmute == $past(ctl_req.wdata[1]))
      else $error("left phones fields not stored");

   a_rhp_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_RHP)
      |=> cfg.right_phones_volume == $past(ctl_req.wdata[7:2])
          && cfg.right_phones_unmute == $past(ctl_req.wdata[1])
          && cfg.phones_output_mode == $past(ctl_req.wdata[0]))
      else $error("right phones fields not stored");

   a_llo_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_LLO)
      |=> cfg.left_line_volume == $past(ctl_req.wdata[7:2])
          && cfg.left_line_unmute == $past(ctl_req.wdata[1])
          && cfg.left_line_mode == $past(ctl_req.wdata[0]))
      else $error("left line fields not stored");

   a_rlo_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_RLO)
      |=> cfg.right_line_volume == $past(ctl_req.wdata[7:2])
          && cfg.right_line_unmute == $past(ctl_req.wdata[1])
          && cfg.right_line_mode == $past(ctl_req.wdata[0]))
      else $error("right line fields not stored");

   a_mono_out_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_MOUT)
      |=> cfg.mono_volume == $past(ctl_req.wdata[7:2])
          && cfg.mono_unmute == $past(ctl_req.wdata[1])
          && cfg.mono_output_mode == $past(ctl_req.wdata[0]))
      else $error("mono output fields not stored");

   a_mixer_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_MONO)
      |=> cfg.mono_mixer_mode == pcr_mono_mode_t'($past(ctl_req.wdata[2:1]))
          && cfg.mono_mixer_enable == $past(ctl_req.wdata[0]))
      else $error("mono mixer fields not stored");

   a_slew_sel_store: assert property (
      (ctl_req.wr && ctl_req.addr == PCR_ADDR_POP)
      |=> cfg.volume_slew_sel == pcr_slew_t'($past(ctl_req.wdata[2:1])))
      else $error("slew select not stored");

   a_unmapped_write: assert property (
      (ctl_req.wr && (ctl_req.addr < PCR_ADDR_RMIX || ctl_req.addr > PCR_ADDR_POP))
      |=> $stable(cfg))
      else $error("unmapped write changed a setting");

endmodule

`default_nettype wire

// File: tb/pcr_playback_output_control_regs_test.sv
`timescale 1ns/10ps
`default_nettype none

`define CHECK(got, exp) \
   begin \
      checked = checked + 1; \
      if ((got) !== (exp)) \
      begin \
         failures = failures + 1; \
         $display("unexpected at %0t ns: got %h, expected %h", $time, (got), (exp)); \
      end \
   end

module pcr_playback_output_control_regs_test
   import pcr_pkg::*;
;

   ////////////////////////////////////////////////////////////////////////////
   // Short slew counts keep the run brief
   localparam int SHORT_N = 8;
   localparam int MID_N   = 16;
   localparam int LONG_N  = 32;
   localparam int WAIT_MAX = 100;

   // Expected reset values and implemented bits, index 0 at 0x4021
   localparam logic [7:0][7:0] RST_EXP  =
      {8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
   localparam logic [7:0][7:0] MASK_EXP =
      {8'h1E, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h1F};
   localparam logic [3:0][7:0] SLEW_EXP =
      {8'h00, 8'(LONG_N), 8'(MID_N), 8'(SHORT_N)};
   localparam logic [3:0][5:0] VOL_CODES = {6'h15, 6'h3F, 6'h39, 6'h00};

   logic            clk;
   logic            rst;
   pcr_ctl_req_t    ctl_req;
   logic [7:0]      ctl_rdata;
   logic            ctl_rvalid;
   pcr_cfg_t        cfg;
   pcr_stat_t       stat;
   logic [4:0][6:0] out_gain_db;
   int              failures;
   int              checked;

   ////////////////////////////////////////////////////////////////////////////
   pcr_playback_output_control_regs
   #(
      .SLEW_SHORT_CYCLES (SHORT_N),
      .SLEW_MID_CYCLES   (MID_N),
      .SLEW_LONG_CYCLES  (LONG_N)
   )
   dut
   (
      .clk         (clk),
      .rst         (rst),
      .ctl_req     (ctl_req),
      .ctl_rdata   (ctl_rdata),
      .ctl_rvalid  (ctl_rvalid),
      .cfg         (cfg),
      .stat        (stat),
      .out_gain_db (out_gain_db)
   );

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // One request per falling edge; the rising edge in between takes it
   task automatic drive(input logic w, input logic r, input logic [15:0] a,
                        input logic [7:0] d);
      begin
         ctl_req = '{wr: w, rd: r, addr: a, wdata: d};
         @(negedge clk);
      end
   endtask

   // Returns two edges later, so stat and gains have settled too
   task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
      begin
         drive(1'b1, 1'b0, a, d);
         drive(1'b0, 1'b0, a, 8'h00);
      end
   endtask

   task automatic reg_read(input logic [15:0] a, input logic [7:0] exp);
      begin
         drive(1'b0, 1'b1, a, 8'h00);
         `CHECK(ctl_rvalid, 1'b1)
         `CHECK(ctl_rdata, exp)
         drive(1'b0, 1'b0, a, 8'h00);
         `CHECK(ctl_rvalid, 1'b0)
      end
   endtask

   // Volume register contents as seen on the cfg fields
   function automatic logic [7:0] vol_byte(input int v);
      case (v)
         0: vol_byte = {cfg.left_phones_volume, cfg.left_phones_unmute,
                        cfg.phones_volume_enable};
         1: vol_byte = {cfg.right_phones_volume, cfg.right_phones_unmute,
                        cfg.phones_output_mode};
         2: vol_byte = {cfg.left_line_volume, cfg.left_line_unmute, cfg.left_line_mode};
         3: vol_byte = {cfg.right_line_volume, cfg.right_line_unmute, cfg.right_line_mode};
         default: vol_byte = {cfg.mono_volume, cfg.mono_unmute, cfg.mono_output_mode};
      endcase
   endfunction

   task automatic wrap_up;
      begin
         $display("comparisons %0d, mismatches %0d", checked, failures);
         if (failures == 0 && checked > 0)
         begin
            $display("bench passed");
         end
         else
         begin
            $display("bench failed");
         end
         $finish;
      end
   endtask

   // Measures how long the slew indicator stays up after a volume write
   task automatic slew_run(input logic [1:0] sel, input logic [7:0] exp);
      int n;
      begin
         reg_write(16'h4028, {5'h00, sel, 1'b0});
         `CHECK(cfg.volume_slew_sel, pcr_slew_t'(sel))
         drive(1'b1, 1'b0, 16'h4025, 8'hE6);
         ctl_req = '0;
         n = 0;
         while (stat.volume_slewing === 1'b1 && n < WAIT_MAX)
         begin
            n = n + 1;
            @(negedge clk);
         end
         if (n >= WAIT_MAX)
         begin
            failures = failures + 1;
            wrap_up();
         end
         else
         begin
            `CHECK(8'(n), exp)
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      failures = 0;
      checked  = 0;
      clk      = 1'b0;
      rst      = 1'b1;
      ctl_req  = '0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      `CHECK(stat, 3'b000)
      `CHECK(cfg.pop_suppress_disable, 1'b0)
      for (int v = 0; v < 5; v++)
      begin
         `CHECK(out_gain_db[v], 7'h47)
      end
      for (int i = 0; i < 8; i++)
      begin
         reg_read(16'h4021 + 16'(i), RST_EXP[i]);
      end
      // Every bit set then cleared; reserved bits must stay zero
      for (int i = 0; i < 8; i++)
      begin
         reg_write(16'h4021 + 16'(i), 8'hFF);
         reg_read(16'h4021 + 16'(i), MASK_EXP[i]);
         reg_write(16'h4021 + 16'(i), 8'h00);
         reg_read(16'h4021 + 16'(i), 8'h00);
      end
      // Unmapped neighbours neither store nor alias
      reg_write(16'h4023, 8'hA6);
      reg_read(16'h4023, 8'hA6);
      reg_write(16'h4020, 8'hFF);
      reg_write(16'h4029, 8'hFF);
      reg_read(16'h4029, 8'h00);
      reg_read(16'h4020, 8'h00);
      reg_read(16'h4021, 8'h00);
      // An offset below the bank wraps onto the last index if decode is loose
      reg_read(16'h4028, 8'h00);
      for (int k = 0; k < 16; k++)
      begin
         reg_write(16'h4021, {3'h0, 2'(k >> 2), 2'(k), k[0]});
         `CHECK(cfg.rmix_from_right_boost, pcr_boost_t'(2'(k >> 2)))
         `CHECK(cfg.rmix_from_left_boost, pcr_boost_t'(2'(k)))
         `CHECK(cfg.right_out_mixer_enable, k[0])
      end
      for (int m = 0; m < 4; m++)
      begin
         reg_write(16'h4022, {5'h00, 2'(m), ~m[0]});
         `CHECK(cfg.mono_mixer_mode, pcr_mono_mode_t'(2'(m)))
         `CHECK(cfg.mono_mixer_enable, ~m[0])
         `CHECK(stat.mono_volume_active, (m != 0))
      end
      // Capless phones: common-mode mixer with the mono output in phones mode
      reg_write(16'h4022, 8'h01);
      reg_write(16'h4027, 8'h03);
      `CHECK(cfg.mono_output_mode, 1'b1)
      `CHECK(stat.mono_volume_active, 1'b0)
      for (int k = 0; k < 4; k++)
      begin
         reg_write(16'h4023, {6'h39, 1'b1, k[0]});
         reg_write(16'h4024, {6'h3F, 1'b1, k[1]});
         `CHECK(cfg.phones_output_mode, k[1])
         `CHECK(stat.phones_enable, k[0] | k[1])
      end
      // Boundary volume codes and 0x15, with mute and mode bits in all patterns
      for (int v = 0; v < 5; v++)
      begin
         for (int j = 0; j < 4; j++)
         begin
            reg_write(16'h4023 + 16'(v), {VOL_CODES[j], j[0], j[1]});
            `CHECK(vol_byte(v), {VOL_CODES[j], j[0], j[1]})
            `CHECK(out_gain_db[v], 7'(VOL_CODES[j]) - 7'd57)
         end
      end
      reg_write(16'h4028, 8'h10);
      `CHECK(cfg.pop_suppress_power_sel, 1'b1)
      `CHECK(cfg.pop_suppress_disable, 1'b0)
      reg_write(16'h4028, 8'h08);
      `CHECK(cfg.pop_suppress_power_sel, 1'b0)
      `CHECK(cfg.pop_suppress_disable, 1'b1)
      for (int s = 0; s < 4; s++)
      begin
         slew_run(2'(s), SLEW_EXP[s]);
      end
      // Read and write together return the old value; then back-to-back writes
      reg_write(16'h4025, 8'h55);
      drive(1'b1, 1'b1, 16'h4025, 8'hAB);
      `CHECK(ctl_rdata, 8'h55)
      drive(1'b1, 1'b0, 16'h4026, 8'hCD);
      drive(1'b0, 1'b0, 16'h4026, 8'h00);
      reg_read(16'h4025, 8'hAB);
      reg_read(16'h4026, 8'hCD);
      // Read right behind a write must see the new value
      drive(1'b1, 1'b0, 16'h4023, 8'h5A);
      drive(1'b0, 1'b1, 16'h4023, 8'h00);
      `CHECK(ctl_rdata, 8'h5A)
      drive(1'b1, 1'b0, 16'h4028, 8'hFF);
      drive(1'b0, 1'b1, 16'h4028, 8'h00);
      `CHECK(ctl_rdata, 8'h1E)
      drive(1'b0, 1'b0, 16'h4028, 8'h00);
      // Second reset in mid-run restores the defaults
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHECK(stat, 3'b000)
      `CHECK(out_gain_db[3], 7'h47)
      reg_read(16'h4026, 8'h02);
      reg_read(16'h4028, 8'h00);
      wrap_up();
   end

endmodule

`default_nettype wire
